// file: logic/alu_cfg.svh
/*
  Constants of the subtract and shift datapath: instruction fields, opcodes,
  address modes, flag and control bit positions, register indices, reset values.
  Assumes it is included by its bare name from the design files.
*/
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

`define F_OPC      23:16
`define F_OPC4     23:20
`define F_BRW3     19
`define F_BRW      15
`define F_BYTE     14
`define F_DSEL     13
`define F_FILE     12:0
`define F_TEN_BIT_IMMEDIATE    13:4
`define F_LREG     3:0
`define F_BASE     18:15
`define F_SHB      14:11
`define F_Q        13:11
`define F_D        10:7
`define F_P        6:4
`define F_S        3:0
`define F_FIVE_BIT_IMMEDIATE     4:0
`define F_LTAG     6:5
`define F_ACC      15
`define F_ACCT     14:0

`define OPC_SHL    8'hDD
`define OPC_FILE   8'hB5
`define OPC_TEN_BIT_IMMEDIATE  8'hB1
`define OPC_ACC    8'hCB
`define OPC_W3     4'h5
`define SHL_TAG    3'h0
`define ACC_TAIL   15'h3000
`define LIT_TAG    2'h3

`define AM_DIRECT  3'h0
`define AM_POSTDEC 3'h2
`define AM_POSTINC 3'h3
`define AM_PREDEC  3'h4
`define AM_PREINC  3'h5

`define STEP_BYTE  16'h0001
`define STEP_WORD  16'h0002
`define SHIFT_MAX  16'h000F
`define DEF_DEFAULT_WORK_REG   4'h0

`define FL_C       0
`define FL_Z       1
`define FL_OV      2
`define FL_N       3
`define FL_DC      8
`define FL_SAB     10
`define FL_OAB     11
`define FL_SB      12
`define FL_SA      13
`define FL_OB      14
`define FL_OA      15
`define CT_SECOND_ACC_SATURATE_EN    6
`define CT_SATA    7

`define ACC_GUARD  39:31
`define SAT_POS    40'h007FFFFFFF
`define SAT_NEG    40'hFF80000000

`define RIDX_FLAGS 12'h010
`define RIDX_CTRL  12'h011
`define RIDX_INSTR 12'h012
`define RIDX_AALO  12'h013
`define RIDX_AAHI  12'h014
`define RIDX_ABLO  12'h015
`define RIDX_ABHI  12'h016
`define RIDX_WHI   11:4
`define MEM_SEL    12
`define MEM_AW     12
`define MEM_WORDS  4096

`define FLAGS_RST  16'h0000
`define CTRL_RST   16'h0000

`endif

// file: logic/alu_pkg.sv
/*
  Types of the subtract and shift datapath: bus request, subtractor in and out,
  operation kinds and the whole architectural state.
  Assumes the constants header is compiled alongside.
*/
package alu_pkg;

  typedef enum logic [2:0] {
    OK_NONE, OK_SHL, OK_SUB_F, OK_SUB_L10, OK_SUB_L5, OK_SUB_W, OK_SUB_ACC
  } op_kind_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [12:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic        use_c;
    logic        c_in;
    logic        byte_op;
  } sub_in_t;

  typedef struct packed {
    logic [15:0] diff;
    logic        c;
    logic        dc;
    logic        n;
    logic        ov;
    logic        z;
  } sub_out_t;

  typedef struct packed {
    logic [15:0][15:0] default_work_reg;
    logic [39:0]       first_accumulator;
    logic [39:0]       second_accumulator;
    logic [15:0]       flags;
    logic [15:0]       ctrl;
    logic [23:0]       last_iw;
    logic [31:0]       rdata;
  } core_state_t;

endpackage : alu_pkg

// file: logic/subtract_unit.sv
/*
  Combinational subtractor with borrow for byte and word width and its flags.
  Assumes the caller merges byte results into the untouched upper byte.
*/
`timescale 1ns/1ps
module subtract_unit (
  input  alu_pkg::sub_in_t  in_op,
  output alu_pkg::sub_out_t res
);
  logic        cin;
  logic [16:0] wsum;
  logic [8:0]  lsum;
  logic [4:0]  nib;

  // A borrow of not-carry is the same as adding carry to a plus not b.
  always_comb begin
    cin  = in_op.use_c ? in_op.c_in : 1'b1;
    wsum = {1'b0, in_op.a} + {1'b0, ~in_op.b} + {16'h0000, cin};
    lsum = {1'b0, in_op.a[7:0]} + {1'b0, ~in_op.b[7:0]} + {8'h00, cin};
    nib  = {1'b0, in_op.a[3:0]} + {1'b0, ~in_op.b[3:0]} + {4'h0, cin};
    res  = '0;
    if (in_op.byte_op) begin
      res.diff = {8'h00, lsum[7:0]};
      res.c    = lsum[8];
      res.dc   = nib[4];
      res.n    = lsum[7];
      res.ov   = (in_op.a[7] ^ in_op.b[7]) & (in_op.a[7] ^ lsum[7]);
      res.z    = (lsum[7:0] == 8'h00);
    end else begin
      res.diff = wsum[15:0];
      res.c    = wsum[16];
      res.dc   = lsum[8];
      res.n    = wsum[15];
      res.ov   = (in_op.a[15] ^ in_op.b[15]) & (in_op.a[15] ^ wsum[15]);
      res.z    = (wsum[15:0] == 16'h0000);
    end
  end
endmodule : subtract_unit

// file: logic/data_ram.sv
/*
  Data memory of 8 KB as 16-bit words with byte write enables.
  Assumes one read port read without a clock and one clocked write port.
*/
`timescale 1ns/1ps
`include "alu_cfg.svh"
module data_ram (
  input  logic                 clk,
  input  logic [`MEM_AW-1:0]   raddr,
  output logic [15:0]          rword,
  input  logic                 we,
  input  logic [`MEM_AW-1:0]   waddr,
  input  logic [15:0]          wword,
  input  logic [1:0]           be
);
  logic [15:0] mem [0:`MEM_WORDS-1];

  assign rword = mem[raddr];

  always_ff @(posedge clk) begin
    if (we && be[0]) begin
      mem[waddr][7:0] <= wword[7:0];
    end
    if (we && be[1]) begin
      mem[waddr][15:8] <= wword[15:8];
    end
  end
endmodule : data_ram

// file: logic/subtract_shift_alu.sv
/*
  Subtract and register-count shift datapath with its working registers,
  accumulators, flags and core control, reached over a plain register port.
  Assumes the master never raises both strobes and holds each for one cycle.
*/
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "alu_cfg.svh"

// Notes on behaviour
// - File subtract with borrow: memory minus working register zero minus not-carry.
// - File forms write working register zero or back to the file address.
// - Destination select 0 means working register zero, 1 means file.
// - Size bit 0 is word, 1 is byte, for operands, result and flags.
// - Working register zero is the implied operand of file forms.
// - File field is the data memory byte address, 0 to 8191.
// - With-borrow forms only clear the zero flag, never set it.
// - Ten-bit literal with borrow is subtracted from its register in place.
// - Ten-bit literal forms address their register directly only.
// - Three-operand subtract: base minus source into destination.
// - Base is direct only; source and destination direct or indirect.
// - Five-bit literal with borrow: base minus literal minus not-carry to destination.
// - Accumulator subtract: chosen minus other, stored in chosen.
// - Byte form gives byte size; no suffix or word suffix gives word.
module subtract_shift_alu (
  input  logic              clk,
  input  logic              rst,
  input  alu_pkg::bus_req_t req,
  output logic [31:0]       rdata
);
  alu_pkg::core_state_t st_ff;
  alu_pkg::core_state_t nxt_st;
  alu_pkg::op_kind_t    kind;
  alu_pkg::sub_in_t     sub_in;
  alu_pkg::sub_out_t    sub_out;

  logic [23:0] iw;
  logic        go;
  logic        borrow;
  logic        byte_op;
  logic        is_sub;
  logic        shl_big;
  logic        acc_sel;
  logic        sat_en;
  logic        acc_ovf;
  logic        mem_we;
  logic        ex_we;
  logic [3:0]  src_r;
  logic [3:0]  dst_r;
  logic [3:0]  base_r;
  logic [3:0]  sh_amt;
  logic [2:0]  src_m;
  logic [2:0]  dst_m;
  logic [15:0] step;
  logic [15:0] base_val;
  logic [15:0] src_val;
  logic [15:0] src_ea;
  logic [15:0] dst_ea;
  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic [15:0] f_addr;
  logic [15:0] mem_val;
  logic [15:0] shl_val;
  logic [15:0] result;
  logic [15:0] bw16;
  logic [11:0] mem_raddr;
  logic [11:0] mem_waddr;
  logic [15:0] mem_rd;
  logic [15:0] mem_wd;
  logic [1:0]  mem_be;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  logic [40:0] acc_diff;
  logic [39:0] acc_res;

  function automatic logic [15:0] eff_addr(input logic [2:0]  m,
                                           input logic [15:0] p,
                                           input logic [15:0] s);
    case (m)
      `AM_PREDEC: eff_addr = p - s;
      `AM_PREINC: eff_addr = p + s;
      default:    eff_addr = p;
    endcase
  endfunction : eff_addr

  function automatic logic [15:0] ptr_after(input logic [2:0]  m,
                                            input logic [15:0] p,
                                            input logic [15:0] s);
    case (m)
      `AM_POSTDEC, `AM_PREDEC: ptr_after = p - s;
      `AM_POSTINC, `AM_PREINC: ptr_after = p + s;
      default:                 ptr_after = p;
    endcase
  endfunction : ptr_after

  // Byte results leave the upper byte of a working register untouched.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] v,
                                        input logic        b);
    merge = b ? {old[15:8], v[7:0]} : v;
  endfunction : merge

  always_comb begin
    iw   = req.wdata[23:0];
    go   = req.wr && !req.addr[`MEM_SEL] && (req.addr[11:0] == `RIDX_INSTR);
    kind = alu_pkg::OK_NONE;
    if (go) begin
      if (iw[`F_OPC] == `OPC_SHL && !iw[`F_BRW] && iw[`F_P] == `SHL_TAG) begin
        kind = alu_pkg::OK_SHL;
      end else if (iw[`F_OPC] == `OPC_FILE) begin
        kind = alu_pkg::OK_SUB_F;
      end else if (iw[`F_OPC] == `OPC_TEN_BIT_IMMEDIATE) begin
        kind = alu_pkg::OK_SUB_L10;
      end else if (iw[`F_OPC] == `OPC_ACC && iw[`F_ACCT] == `ACC_TAIL) begin
        kind = alu_pkg::OK_SUB_ACC;
      end else if (iw[`F_OPC4] == `OPC_W3) begin
        kind = (iw[`F_LTAG] == `LIT_TAG) ? alu_pkg::OK_SUB_L5 : alu_pkg::OK_SUB_W;
      end
    end
  end

  always_comb begin
    is_sub  = (kind == alu_pkg::OK_SUB_F) || (kind == alu_pkg::OK_SUB_L10) ||
              (kind == alu_pkg::OK_SUB_L5) || (kind == alu_pkg::OK_SUB_W);
    byte_op = is_sub && iw[`F_BYTE];
    step    = byte_op ? `STEP_BYTE : `STEP_WORD;
    borrow  = ((kind == alu_pkg::OK_SUB_F) || (kind == alu_pkg::OK_SUB_L10)) ?
              iw[`F_BRW] : iw[`F_BRW3];
    src_r   = iw[`F_S];
    src_m   = (kind == alu_pkg::OK_SUB_W) ? iw[`F_P] : `AM_DIRECT;
    dst_r   = (kind == alu_pkg::OK_SUB_L10) ? iw[`F_LREG] : iw[`F_D];
    dst_m   = ((kind == alu_pkg::OK_SUB_L5) || (kind == alu_pkg::OK_SUB_W)) ?
              iw[`F_Q] : `AM_DIRECT;
    if (kind == alu_pkg::OK_SHL) begin
      base_r = iw[`F_SHB];
    end else if (kind == alu_pkg::OK_SUB_L10) begin
      base_r = iw[`F_LREG];
    end else begin
      base_r = iw[`F_BASE];
    end
    base_val = st_ff.default_work_reg[base_r];
    src_ea   = eff_addr(src_m, st_ff.default_work_reg[src_r], step);
    dst_ea   = eff_addr(dst_m, st_ff.default_work_reg[dst_r], step);
    f_addr   = {3'b000, iw[`F_FILE]};
    rd_ea    = (kind == alu_pkg::OK_SUB_F) ? f_addr : src_ea;
    wr_ea    = (kind == alu_pkg::OK_SUB_F) ? f_addr : dst_ea;
    mem_val  = byte_op ? {8'h00, (rd_ea[0] ? mem_rd[15:8] : mem_rd[7:0])} : mem_rd;
    src_val  = (src_m == `AM_DIRECT) ? st_ff.default_work_reg[src_r] : mem_val;
    sh_amt   = st_ff.default_work_reg[src_r][3:0];
    shl_big  = st_ff.default_work_reg[src_r] > `SHIFT_MAX;
    shl_val  = shl_big ? 16'h0000 : (base_val << sh_amt);
  end

  always_comb begin
    sub_in.use_c   = borrow;
    sub_in.c_in    = st_ff.flags[`FL_C];
    sub_in.byte_op = byte_op;
    case (kind)
      alu_pkg::OK_SUB_F: begin
        sub_in.a = mem_val;
        sub_in.b = st_ff.default_work_reg[`DEF_DEFAULT_WORK_REG];
      end
      alu_pkg::OK_SUB_L10: begin
        sub_in.a = base_val;
        sub_in.b = {6'h00, iw[`F_TEN_BIT_IMMEDIATE]};
      end
      alu_pkg::OK_SUB_L5: begin
        sub_in.a = base_val;
        sub_in.b = {11'h000, iw[`F_FIVE_BIT_IMMEDIATE]};
      end
      default: begin
        sub_in.a = base_val;
        sub_in.b = src_val;
      end
    endcase
    bw16   = {15'h0000, borrow & !st_ff.flags[`FL_C]};
    result = sub_out.diff;
  end

  subtract_unit u_sub (
    .in_op (sub_in),
    .res   (sub_out)
  );

  always_comb begin
    acc_sel  = iw[`F_ACC];
    acc_a    = acc_sel ? st_ff.second_accumulator : st_ff.first_accumulator;
    acc_b    = acc_sel ? st_ff.first_accumulator : st_ff.second_accumulator;
    acc_diff = {acc_a[39], acc_a} - {acc_b[39], acc_b};
    sat_en   = acc_sel ? st_ff.ctrl[`CT_SECOND_ACC_SATURATE_EN] : st_ff.ctrl[`CT_SATA];
    acc_ovf  = (acc_diff[40] != acc_diff[39]) ||
               !((&acc_diff[`ACC_GUARD]) || !(|acc_diff[`ACC_GUARD]));
    if (sat_en && acc_ovf) begin
      acc_res = acc_diff[40] ? `SAT_NEG : `SAT_POS;
    end else begin
      acc_res = acc_diff[39:0];
    end
  end

  always_comb begin
    ex_we     = ((kind == alu_pkg::OK_SUB_F) && iw[`F_DSEL]) ||
                (((kind == alu_pkg::OK_SUB_L5) || (kind == alu_pkg::OK_SUB_W)) &&
                 (dst_m != `AM_DIRECT));
    mem_we    = ex_we || (req.wr && req.addr[`MEM_SEL]);
    mem_raddr = req.rd ? req.addr[11:0] : rd_ea[12:1];
    mem_waddr = ex_we ? wr_ea[12:1] : req.addr[11:0];
    if (!ex_we) begin
      mem_wd = req.wdata[15:0];
      mem_be = 2'b11;
    end else if (byte_op) begin
      mem_wd = {result[7:0], result[7:0]};
      mem_be = wr_ea[0] ? 2'b10 : 2'b01;
    end else begin
      mem_wd = result;
      mem_be = 2'b11;
    end
  end

  data_ram u_ram (
    .clk   (clk),
    .raddr (mem_raddr),
    .rword (mem_rd),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wword (mem_wd),
    .be    (mem_be)
  );

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 32'h0000_0000;
    if (go) begin
      nxt_st.last_iw = iw;
    end
    if (kind == alu_pkg::OK_SHL) begin
      nxt_st.default_work_reg[dst_r]       = shl_val;
      nxt_st.flags[`FL_N]      = shl_val[15];
      nxt_st.flags[`FL_Z]      = (shl_val == 16'h0000);
    end
    if (is_sub) begin
      if (kind == alu_pkg::OK_SUB_W) begin
        nxt_st.default_work_reg[src_r] = ptr_after(src_m, st_ff.default_work_reg[src_r], step);
      end
      if (dst_m != `AM_DIRECT) begin
        nxt_st.default_work_reg[dst_r] = ptr_after(dst_m, st_ff.default_work_reg[dst_r], step);
      end
      if (kind == alu_pkg::OK_SUB_F) begin
        if (!iw[`F_DSEL]) begin
          nxt_st.default_work_reg[`DEF_DEFAULT_WORK_REG] = merge(st_ff.default_work_reg[`DEF_DEFAULT_WORK_REG], result, byte_op);
        end
      end else if (dst_m == `AM_DIRECT) begin
        nxt_st.default_work_reg[dst_r] = merge(st_ff.default_work_reg[dst_r], result, byte_op);
      end
      nxt_st.flags[`FL_C]  = sub_out.c;
      nxt_st.flags[`FL_DC] = sub_out.dc;
      nxt_st.flags[`FL_N]  = sub_out.n;
      nxt_st.flags[`FL_OV] = sub_out.ov;
      nxt_st.flags[`FL_Z]  = borrow ? (st_ff.flags[`FL_Z] & sub_out.z) : sub_out.z;
    end
    if (kind == alu_pkg::OK_SUB_ACC) begin
      if (acc_sel) begin
        nxt_st.second_accumulator          = acc_res;
        nxt_st.flags[`FL_OB] = !((&acc_res[`ACC_GUARD]) || !(|acc_res[`ACC_GUARD]));
        nxt_st.flags[`FL_SB] = st_ff.flags[`FL_SB] | acc_ovf;
      end else begin
        nxt_st.first_accumulator          = acc_res;
        nxt_st.flags[`FL_OA] = !((&acc_res[`ACC_GUARD]) || !(|acc_res[`ACC_GUARD]));
        nxt_st.flags[`FL_SA] = st_ff.flags[`FL_SA] | acc_ovf;
      end
      nxt_st.flags[`FL_OAB] = nxt_st.flags[`FL_OA] | nxt_st.flags[`FL_OB];
      nxt_st.flags[`FL_SAB] = nxt_st.flags[`FL_SA] | nxt_st.flags[`FL_SB];
    end
    if (req.wr && !req.addr[`MEM_SEL]) begin
      if (req.addr[`RIDX_WHI] == 8'h00) begin
        nxt_st.default_work_reg[req.addr[3:0]] = req.wdata[15:0];
      end
      case (req.addr[11:0])
        `RIDX_FLAGS: nxt_st.flags       = req.wdata[15:0];
        `RIDX_CTRL:  nxt_st.ctrl        = req.wdata[15:0];
        `RIDX_AALO:  nxt_st.first_accumulator[31:0]  = req.wdata;
        `RIDX_AAHI:  nxt_st.first_accumulator[39:32] = req.wdata[7:0];
        `RIDX_ABLO:  nxt_st.second_accumulator[31:0]  = req.wdata;
        `RIDX_ABHI:  nxt_st.second_accumulator[39:32] = req.wdata[7:0];
        default:     nxt_st.rdata       = 32'h0000_0000;
      endcase
    end
    if (req.rd && req.addr[`MEM_SEL]) begin
      nxt_st.rdata = {16'h0000, mem_rd};
    end else if (req.rd && req.addr[`RIDX_WHI] == 8'h00) begin
      nxt_st.rdata = {16'h0000, st_ff.default_work_reg[req.addr[3:0]]};
    end else if (req.rd) begin
      case (req.addr[11:0])
        `RIDX_FLAGS: nxt_st.rdata = {16'h0000, st_ff.flags};
        `RIDX_CTRL:  nxt_st.rdata = {16'h0000, st_ff.ctrl};
        `RIDX_INSTR: nxt_st.rdata = {8'h00, st_ff.last_iw};
        `RIDX_AALO:  nxt_st.rdata = st_ff.first_accumulator[31:0];
        `RIDX_AAHI:  nxt_st.rdata = {24'h000000, st_ff.first_accumulator[39:32]};
        `RIDX_ABLO:  nxt_st.rdata = st_ff.second_accumulator[31:0];
        `RIDX_ABHI:  nxt_st.rdata = {24'h000000, st_ff.second_accumulator[39:32]};
        default:     nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.flags <= `FLAGS_RST;
      st_ff.ctrl  <= `CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;

  shl_zero_fill_a: assert property (
    @(posedge clk) disable iff (rst)
    (kind == alu_pkg::OK_SHL && shl_big) |=> st_ff.default_work_reg[$past(dst_r)] == 16'h0000)
    else $error("Oversized shift count did not clear the destination.");

  shl_value_a: assert property (
    @(posedge clk) disable iff (rst)
    (kind == alu_pkg::OK_SHL && !shl_big) |=>
      st_ff.default_work_reg[$past(dst_r)] == ($past(base_val) << $past(sh_amt)))
    else $error("Shift destination differs from the shifted base.");

  file_to_w0_a: assert property (
    @(posedge clk) disable iff (rst)
    (kind == alu_pkg::OK_SUB_F && !iw[`F_DSEL] && !byte_op) |=>
      st_ff.default_work_reg[`DEF_DEFAULT_WORK_REG] == $past(result))
    else $error("File subtract did not land in working register zero.");

  file_to_mem_a: assert property (
    @(posedge clk) disable iff (rst)
    (kind == alu_pkg::OK_SUB_F && iw[`F_DSEL]) |->
      mem_we && mem_waddr == f_addr[12:1] && !req.rd)
    else $error("File subtract did not write back to its file address.");

  sticky_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    (is_sub && borrow && !st_ff.flags[`FL_Z]) |=> !st_ff.flags[`FL_Z])
    else $error("Borrow subtract set the zero flag.");

  ten_bit_immediate_writeback_a: assert property (
    @(posedge clk) disable iff (rst)
    (kind == alu_pkg::OK_SUB_L10 && !byte_op) |=>
      st_ff.default_work_reg[$past(dst_r)] == $past(base_val) - $past(sub_in.b) - $past(bw16))
    else $error("Ten-bit literal subtract wrote a wrong difference.");

  acc_other_kept_a: assert property (
    @(posedge clk) disable iff (rst)
    (kind == alu_pkg::OK_SUB_ACC && !acc_sel) |=>
      $stable(st_ff.second_accumulator) && st_ff.first_accumulator == $past(acc_res))
    else $error("Accumulator subtract touched the wrong accumulator.");

  acc_sat_a: assert property (
    @(posedge clk) disable iff (rst)
    (kind == alu_pkg::OK_SUB_ACC && acc_sel && sat_en) |=>
      ((&st_ff.second_accumulator[`ACC_GUARD]) || !(|st_ff.second_accumulator[`ACC_GUARD])))
    else $error("Saturating accumulator left its range.");

  read_window_a: assert property (
    @(posedge clk) disable iff (rst)
    (req.rd && req.addr[11:0] == `RIDX_FLAGS && !req.addr[`MEM_SEL]) |=>
      rdata == {16'h0000, $past(st_ff.flags)} ##1 rdata == 32'h0000_0000 || $past(req.rd))
    else $error("Flags read did not return for exactly one cycle.");

endmodule : subtract_shift_alu

// file: dv/subtract_shift_alu_tb.sv
/*
  Self-checking bench of the subtract and shift datapath: reset state, table of operations,
  then sticky zero, indirect operands, accumulators and a second reset.
  Assumes the plain register port with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
module subtract_shift_alu_tb;
  localparam logic [12:0] A_FL  = 13'h0010;
  localparam logic [12:0] A_CT  = 13'h0011;
  localparam logic [12:0] A_IN  = 13'h0012;
  localparam logic [12:0] A_AAL = 13'h0013;
  localparam logic [12:0] A_AAH = 13'h0014;
  localparam logic [12:0] A_ABL = 13'h0015;
  localparam logic [12:0] A_ABH = 13'h0016;

  typedef struct packed {
    logic [12:0] ra;
    logic [15:0] va;
    logic [12:0] rb;
    logic [15:0] vb;
    logic [15:0] fl;
    logic [23:0] iw;
    logic [12:0] ca;
    logic [31:0] ex;
  } row_t;

  logic              clk;
  logic              rst;
  alu_pkg::bus_req_t req;
  logic [31:0]       rdata;
  logic [31:0]       v;
  int                n_errors;
  int                samples_checked;

  // Each row sets two places and the flags, runs one instruction, reads one result.
  row_t rows [14] = '{
    '{13'h0001, 16'h1234, 13'h0002, 16'h0004, 16'h0000, 24'hDD0982, 13'h0003, 32'h2340},
    '{13'h0001, 16'h0003, 13'h0002, 16'h000F, 16'h0000, 24'hDD0982, 13'h0003, 32'h8000},
    '{13'h0001, 16'hFFFF, 13'h0002, 16'h0104, 16'h0000, 24'hDD0982, 13'h0003, 32'h0000},
    '{13'h0001, 16'hFFFF, 13'h0002, 16'h0010, 16'h0000, 24'hDD0982, 13'h0003, 32'h0000},
    '{13'h1502, 16'h6235, 13'h0000, 16'h6234, 16'h0000, 24'hB58A04, 13'h0000, 32'h0000},
    '{13'h1FFF, 16'h9439, 13'h0000, 16'h7804, 16'h0001, 24'hB5BFFE, 13'h1FFF, 32'h1C35},
    '{13'h1FFF, 16'h9439, 13'h0000, 16'h7804, 16'h0000, 24'hB5FFFF, 13'h1FFF, 32'h8F39},
    '{13'h1502, 16'h4523, 13'h0000, 16'h6234, 16'h0000, 24'hB50A04, 13'h0000, 32'hE2EF},
    '{13'h0004, 16'h6234, 13'h0004, 16'h6234, 16'h0001, 24'hB19084, 13'h0004, 32'h612C},
    '{13'h0005, 16'h0400, 13'h0005, 16'h0400, 16'h0000, 24'hB13FF5, 13'h0005, 32'h0001},
    '{13'h0000, 16'h7804, 13'h0000, 16'h7804, 16'h0000, 24'hB1C230, 13'h0000, 32'h78E0},
    '{13'h0007, 16'h2450, 13'h0008, 16'h92E4, 16'h0001, 24'h538488, 13'h0009, 32'h916C},
    '{13'h0007, 16'h2450, 13'h0008, 16'h92E4, 16'h0000, 24'h5B8488, 13'h0009, 32'h916B},
    '{13'h0004, 16'h7804, 13'h0004, 16'h7804, 16'h0000, 24'h5A4270, 13'h0004, 32'h78F3}
  };

  subtract_shift_alu dut_u (
    .clk   (clk),
    .rst   (rst),
    .req   (req),
    .rdata (rdata)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
  endtask : wr

  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd

  task automatic rc(input logic [12:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask : rc

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    n_errors = 0;
    samples_checked = 0;
    req = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rc(A_FL + 13'(i), 32'h0, "state after reset");
    end
    foreach (rows[i]) begin
      wr(rows[i].ra, {16'h0000, rows[i].va});
      wr(rows[i].rb, {16'h0000, rows[i].vb});
      wr(A_FL, {16'h0000, rows[i].fl});
      wr(A_IN, {8'h00, rows[i].iw});
      rc(rows[i].ca, rows[i].ex, $sformatf("row %0d", i));
    end
    // The last row is a byte subtract, so its sign comes from bit 7 of the byte.
    rd(A_FL, v);
    chk("byte flags", {30'h0, v[3], v[0]}, 32'h2);
    wr(13'h0FFF, 32'h0000FFFF);
    rc(13'h0FFF, 32'h0, "unmapped read");
    // Zero result keeps a set zero flag; a non-zero one clears it.
    wr(13'h1502, 32'h6234);
    wr(13'h0000, 32'h6234);
    wr(A_FL, 32'h0003);
    wr(A_IN, 32'hB58A04);
    rd(A_FL, v);
    chk("zero flag kept", {31'h0, v[1]}, 32'h1);
    rc(A_IN, 32'h00B58A04, "instruction readback");
    wr(13'h0000, 32'h0001);
    wr(A_FL, 32'h0003);
    wr(A_IN, 32'hB58A04);
    rd(A_FL, v);
    chk("zero flag cleared", {31'h0, v[1]}, 32'h0);
    rc(13'h0000, 32'h6233, "default register result");
    // Indirect source and destination with post-increment of both pointers.
    wr(13'h0007, 32'h2450);
    wr(13'h0008, 32'h1808);
    wr(13'h0009, 32'h0022);
    wr(13'h1C04, 32'h92E4);
    wr(A_IN, 32'h539CB8);
    rc(13'h1011, 32'h916C, "indirect result");
    rc(13'h0008, 32'h180A, "source pointer");
    rc(13'h0009, 32'h0024, "destination pointer");
    // Pre-decrement source into a plain indirect destination.
    wr(A_IN, 32'h538CC8);
    rc(13'h1012, 32'h916C, "predec result");
    rc(13'h0008, 32'h1808, "predec pointer");
    rc(13'h0009, 32'h0024, "plain indirect pointer");
    // Post-decrement source into a pre-incremented destination.
    wr(A_IN, 32'h53ACA8);
    rc(13'h1013, 32'h916C, "preinc result");
    rc(13'h0008, 32'h1806, "postdec pointer");
    rc(13'h0009, 32'h0026, "preinc pointer");
    wr(A_AAL, 32'h120F098A);
    wr(A_AAH, 32'h76);
    wr(A_ABL, 32'hF312BC17);
    wr(A_ABH, 32'h23);
    wr(A_CT, 32'h0);
    wr(A_IN, 32'hCB3000);
    rc(A_AAL, 32'h1EFC4D73, "acc a low");
    rc(A_AAH, 32'h52, "acc a high");
    rc(A_ABL, 32'hF312BC17, "acc b kept");
    wr(A_AAL, 32'h90222EE1);
    wr(A_AAH, 32'hFF);
    wr(A_ABL, 32'h24568F4C);
    wr(A_ABH, 32'h0);
    wr(A_CT, 32'h40);
    wr(A_IN, 32'hCBB000);
    rc(A_ABL, 32'h7FFFFFFF, "acc b saturated low");
    rc(A_ABH, 32'h0, "acc b saturated high");
    rc(A_AAH, 32'hFF, "acc a kept");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(13'h0004, 32'h0, "register after second reset");
    rc(A_ABH, 32'h0, "acc after second reset");
    stop_test();
  end
endmodule : subtract_shift_alu_tb
